/* rtl/start_collision_pkg.sv */
// constants and types for the start generator with collision detection
`default_nettype none
package start_collision_pkg;
  localparam int unsigned BAUD_W = 8;
  localparam logic [BAUD_W-1:0] BAUD_RELOAD_DEFAULT = 8'h04;
  localparam logic [BAUD_W-1:0] BAUD_ZERO = 8'h00;
  localparam logic [BAUD_W-1:0] BAUD_ONE = 8'h01;
  localparam int unsigned SYNC_STAGES = 2;
  localparam logic [1:0] SYNC_RESET = 2'h3;
  localparam logic [1:0] RESET_SYNC_INIT = 2'h0;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CHECK,
    ST_SDA_WAIT,
    ST_SCL_WAIT,
    ST_DONE
  } start_state_e;
endpackage : start_collision_pkg
`default_nettype wire

/* rtl/line_sync_if.sv */
// synchronised bus-line levels passed from the sampler to the sequencer
`default_nettype none
interface line_sync_if;
  logic sda;
  logic scl;
  modport src (output sda, output scl);
  modport dst (input sda, input scl);
endinterface : line_sync_if
`default_nettype wire

/* rtl/line_sampler.sv */
// two-flop synchronisers for the sda and scl pin inputs
`default_nettype none
module line_sampler (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // raw pins
  input wire logic sda_i,
  input wire logic scl_i,
  // synchronised levels
  line_sync_if.src lines
);
  import start_collision_pkg::*;
  logic [1:0] sda_sync;
  logic [1:0] scl_sync;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sda_sync <= SYNC_RESET;
      scl_sync <= SYNC_RESET;
    end else begin
      sda_sync <= {sda_sync[0], sda_i};
      scl_sync <= {scl_sync[0], scl_i};
    end
  end
  assign lines.sda = sda_sync[1];
  assign lines.scl = scl_sync[1];
endmodule // line_sampler
`default_nettype wire

/* rtl/baud_counter.sv */
// reloadable baud-rate down counter
`default_nettype none
module baud_counter #(
  parameter int unsigned WIDTH = start_collision_pkg::BAUD_W
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // control
  input wire logic load_i,
  input wire logic clear_i,
  input wire logic run_i,
  input wire logic [WIDTH-1:0] reload_i,
  // status
  output logic expire_o
);
  import start_collision_pkg::*;
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  assign next_count = clear_i ? WIDTH'(BAUD_ZERO) :
                      load_i ? reload_i :
                      (run_i && count != WIDTH'(BAUD_ZERO)) ? count - WIDTH'(BAUD_ONE) : count;
  // no load term here: the sequencer's load decode reads expire_o
  assign expire_o = run_i && count == WIDTH'(BAUD_ONE);
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= WIDTH'(BAUD_ZERO);
    end else begin
      count <= next_count;
    end
  end
endmodule // baud_counter
`default_nettype wire

/* rtl/start_collision.sv */
// start-condition generator with bus-collision detection
`default_nettype none
// Summary of operation
// - either line low when start begins flags a collision.
// - scl low while sda still high before our sda drive flags collision.
// - both lines checked at start; scl then checked every cycle until our sda drive.
// - collision aborts start, sets flag, returns sequencer to idle.
// - begin released; once sda high, load baud counter and count down.
// - sda low during first count reloads counter and drives sda at once.
// - sda high through first count: drive sda low at its expiry.
// - reload after sda low; scl low then is no collision.
// - second count expiry drives scl low, completing the start.
// - near-simultaneous starts are not collisions; address arbitration settles.
module start_collision #(
  parameter logic [start_collision_pkg::BAUD_W-1:0] BAUD_RELOAD =
    start_collision_pkg::BAUD_RELOAD_DEFAULT
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // command and status
  input wire logic start_req_i,
  input wire logic collision_clear_i,
  output logic bus_collision_flag_o,
  output logic start_done_o,
  output logic busy_o,
  // sda pin
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // scl pin
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o
);
  import start_collision_pkg::*;

  logic [1:0] rst_sync;
  logic rst_n;
  line_sync_if lines ();
  start_state_e state;
  start_state_e next_state;
  logic sda_drive;
  logic next_sda_drive;
  logic scl_drive;
  logic next_scl_drive;
  logic flag;
  logic done;
  logic baud_load;
  logic baud_clear;
  logic baud_run;
  logic baud_expire;
  logic collide_begin;
  logic collide_scl;
  logic collision;
  logic sda_seen_low;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync <= RESET_SYNC_INIT;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  line_sampler u_sampler (
    .clock_i(clock_i),
    .rst_n_i(rst_n),
    .sda_i(sda_i),
    .scl_i(scl_i),
    .lines(lines)
  );

  baud_counter #(.WIDTH(BAUD_W)) u_baud (
    .clock_i(clock_i),
    .rst_n_i(rst_n),
    .load_i(baud_load),
    .clear_i(baud_clear),
    .run_i(baud_run),
    .reload_i(BAUD_RELOAD),
    .expire_o(baud_expire)
  );

  // collision terms
  assign collide_begin = (state == ST_CHECK) && (!lines.sda || !lines.scl);
  // another master pulling scl low while sda is still high
  assign collide_scl = (state == ST_SDA_WAIT) && lines.sda && !lines.scl;
  // scl low in ST_SCL_WAIT deliberately ignored
  assign collision = collide_begin || collide_scl;
  assign sda_seen_low = (state == ST_SDA_WAIT) && !lines.sda;

  assign baud_load = ((state == ST_CHECK) && !collision) ||
                     ((state == ST_SDA_WAIT) && (baud_expire || sda_seen_low));
  assign baud_clear = collision || (state == ST_IDLE);
  assign baud_run = (state == ST_SDA_WAIT) || (state == ST_SCL_WAIT);

  always_comb begin
    next_state = state;
    next_sda_drive = sda_drive;
    next_scl_drive = scl_drive;
    case (state)
      ST_IDLE: begin
        next_sda_drive = 1'b0;
        next_scl_drive = 1'b0;
        if (start_req_i) begin
          next_state = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (collision) begin
          next_state = ST_IDLE;
        end else begin
          next_state = ST_SDA_WAIT;
        end
      end
      ST_SDA_WAIT: begin
        if (collision) begin
          next_state = ST_IDLE;
        end else if (sda_seen_low || baud_expire) begin
          next_sda_drive = 1'b1;
          next_state = ST_SCL_WAIT;
        end
      end
      ST_SCL_WAIT: begin
        if (baud_expire) begin
          next_scl_drive = 1'b1;
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
        next_sda_drive = 1'b0;
        next_scl_drive = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      sda_drive <= 1'b0;
      scl_drive <= 1'b0;
      done <= 1'b0;
    end else begin
      state <= next_state;
      sda_drive <= next_sda_drive;
      scl_drive <= next_scl_drive;
      done <= (state == ST_SCL_WAIT) && baud_expire;
    end
  end

  // set wins over clear
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      flag <= 1'b0;
    end else if (collision) begin
      flag <= 1'b1;
    end else if (collision_clear_i) begin
      flag <= 1'b0;
    end
  end

  // scl hold after start is left to the next phase; released on idle here
  assign sda_o = 1'b0;
  assign scl_o = 1'b0;
  assign sda_oe_o = sda_drive;
  assign scl_oe_o = scl_drive;
  assign bus_collision_flag_o = flag;
  assign start_done_o = done;
  assign busy_o = (state != ST_IDLE);
endmodule // start_collision
`default_nettype wire

/* test/start_collision_assertions.sv */
// concurrent checks on the start generator ports
`default_nettype none
module start_collision_assertions #(
  parameter int R = 4
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic collision_clear_i,
  input wire logic bus_collision_flag_o,
  input wire logic start_done_o,
  input wire logic busy_o,
  input wire logic sda_i,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic scl_o,
  input wire logic sda_oe_o,
  input wire logic scl_oe_o
);
  timeunit 1ns / 1ps;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  drain_a: assert property (!sda_o && !scl_o) else $error("pin high");
  cause_a: assert property ($rose(bus_collision_flag_o) |->
    !$past(sda_i, 3) || !$past(scl_i, 3)) else $error("no cause");
  abort_a: assert property ($rose(bus_collision_flag_o) |-> !busy_o && !sda_oe_o)
    else $error("no abort");
  late_scl_a: assert property ($rose(bus_collision_flag_o) |-> !$past(sda_oe_o))
    else $error("late flag");
  flag_hold_a: assert property (bus_collision_flag_o && !collision_clear_i |=>
    bus_collision_flag_o) else $error("flag lost");
  flag_clear_a: assert property (collision_clear_i && !busy_o |=>
    !bus_collision_flag_o) else $error("flag stuck");
  scl_order_a: assert property (scl_oe_o |-> sda_oe_o) else $error("scl first");
  second_count_a: assert property ($rose(scl_oe_o) |-> $past(sda_oe_o, R) &&
    !$past(sda_oe_o, R + 1) ##0 start_done_o ##1 !start_done_o) else $error("bad count");
  busy_end_a: assert property ($rose(busy_o) |-> ##[1:40] !busy_o) else $error("hang");
  cover property ($rose(bus_collision_flag_o));
  cover property ($rose(start_done_o));
  cover property (sda_oe_o && !scl_i);
endmodule // start_collision_assertions
bind start_collision start_collision_assertions #(.R(BAUD_RELOAD)) chk (.*);
`default_nettype wire

/* test/bus_partner.sv */
// other masters and slaves sharing the two open-drain lines
`default_nettype none
module bus_partner (
  // device pull-downs
  input wire logic dev_sda_oe_i,
  input wire logic dev_scl_oe_i,
  // another master pulling low
  input wire logic pull_sda_i,
  input wire logic pull_scl_i,
  // wired-and levels with pull-ups
  output logic sda_o,
  output logic scl_o
);
  timeunit 1ns / 1ps;
  assign sda_o = !(dev_sda_oe_i || pull_sda_i);
  assign scl_o = !(dev_scl_oe_i || pull_scl_i);
endmodule // bus_partner
`default_nettype wire

/* test/testbench.sv */
// self-checking bench for the start generator
`default_nettype none
module testbench;
  timeunit 1ns / 1ps;
  localparam int R = 8;
  logic clock_i = 0, rst_n_i = 0, req = 0, clr = 0, psda = 0, pscl = 0;
  logic flag, done, busy, sda, scl, sda_oe, scl_oe, s_done, s_flag;
  int n_mismatch = 0, checks_done = 0, c1, c2;
  start_collision #(.BAUD_RELOAD(8'h08)) uut (.clock_i, .rst_n_i, .start_req_i(req),
    .collision_clear_i(clr), .bus_collision_flag_o(flag), .start_done_o(done),
    .busy_o(busy), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe), .scl_i(scl), .scl_o(),
    .scl_oe_o(scl_oe));
  bus_partner far (.dev_sda_oe_i(sda_oe), .dev_scl_oe_i(scl_oe), .pull_sda_i(psda),
    .pull_scl_i(pscl), .sda_o(sda), .scl_o(scl));
  initial begin
    forever #12.5 clock_i = ~clock_i;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // one request; another master pulls a line at the given count
  task automatic run(input int sda1, input int scl1, input int scl2);
    int n;
    c1 = 0;
    c2 = 0;
    s_done = 0;
    s_flag = 0;
    @(negedge clock_i) req = 1;
    @(negedge clock_i) req = 0;
    for (n = 0; n < 60 && busy; n++) begin
      if (c1 == sda1) psda = 1;
      if (c1 == scl1 || c2 == scl2) pscl = 1;
      c1 += int'(busy && !sda_oe);
      c2 += int'(sda_oe && !scl_oe);
      s_done |= done;
      s_flag |= flag;
      @(negedge clock_i);
    end
    s_flag |= flag;
    if (n == 60) begin
      n_mismatch++;
      complete_run();
    end
    psda = 0;
    pscl = 0;
    repeat (3) @(negedge clock_i);
  endtask
  task automatic collided();
    check({s_flag, s_done, 1'(c2 == 0)}, 8'h5);
    check(flag, 8'h1);
    @(negedge clock_i) clr = 1;
    @(negedge clock_i) clr = 0;
    check(flag, 8'h0);
  endtask
  task automatic plain_start();
    run(-1, -1, -1);
    check(8'(c1), 8'(R + 1));
    check({s_flag, s_done, 6'(c2)}, 8'(64 + R));
  endtask
  task automatic early_sda();
    run(2, -1, -1);
    check({s_flag, s_done, 1'(c1 < R)}, 8'h3);
    check(8'(c2), 8'(R));
  endtask
  task automatic late_scl();
    run(-1, -1, 2);
    check({s_flag, s_done, 6'(c2)}, 8'(64 + R));
  endtask
  task automatic scl_first_count();
    run(-1, 3, -1);
    collided();
  endtask
  task automatic scl_at_start();
    pscl = 1;
    repeat (3) @(negedge clock_i);
    run(-1, -1, -1);
    collided();
  endtask
  task automatic sda_at_start();
    psda = 1;
    repeat (3) @(negedge clock_i);
    run(-1, -1, -1);
    collided();
  endtask
  initial begin
    repeat (10) @(negedge clock_i);
    rst_n_i = 1;
    repeat (4) @(negedge clock_i);
    plain_start();
    early_sda();
    late_scl();
    scl_first_count();
    scl_at_start();
    sda_at_start();
    complete_run();
  end
endmodule // testbench
`default_nettype wire
